/* hw/add_exec_pkg.sv */
// package: opcodes, register map, field positions and reset values of the add datapath
package add_exec_pkg;

  // ****************************************************************
  // register map on the plain register port
  // ****************************************************************
  localparam int REG_ADDR_W = 3;
  localparam logic [2:0] REG_ACC = 3'h0;
  localparam logic [2:0] REG_BANK = 3'h1;
  localparam logic [2:0] REG_STATUS = 3'h2;
  localparam logic [2:0] REG_CTRL = 3'h3;
  localparam logic [2:0] REG_INDEX_LO = 3'h4;
  localparam logic [2:0] REG_INDEX_HI = 3'h5;

  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] BANK_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [11:0] INDEX_RST = 12'h000;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CTRL_EXT_BIT = 0;
  localparam int ST_C_BIT = 0;
  localparam int ST_DC_BIT = 1;
  localparam int ST_Z_BIT = 2;
  localparam int ST_OV_BIT = 3;
  localparam int ST_N_BIT = 4;
  localparam int INSTR_DEST_BIT = 9;
  localparam int INSTR_BANK_BIT = 8;

  // ****************************************************************
  // opcodes and addressing constants
  // ****************************************************************
  localparam logic [7:0] OPC_LIT = 8'h0F;
  localparam logic [5:0] OPC_WF = 6'h09;
  localparam logic [5:0] OPC_WFC = 6'h08;
  localparam logic [7:0] INDEXED_MAX = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

  typedef enum logic [1:0] {OP_NONE, OP_LIT, OP_WF, OP_WFC} op_t;
  typedef enum logic [2:0] {ST_IDLE, ST_DECODE, ST_READ, ST_PROCESS, ST_WRITE} state_t;

endpackage

/* hw/add8_flags.sv */
// module: 8-bit adder with carry in and the arithmetic flag outputs
`timescale 1ns/1ps
module add8_flags (
  input wire logic [7:0] opA,
  input wire logic [7:0] opB,
  input wire logic carryIn,
  output logic [7:0] sum,
  output logic carryOut,
  output logic digitCarry,
  output logic overflow,
  output logic negative,
  output logic zero
);
  logic [8:0] full;
  logic [4:0] lowNibble;

  // nibble sum gives the digit carry without a second full adder
  assign full = {1'b0, opA} + {1'b0, opB} + {8'h00, carryIn};
  assign lowNibble = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, carryIn};
  assign sum = full[7:0];
  assign carryOut = full[8];
  assign digitCarry = lowNibble[4];
  // signed overflow: equal operand signs, different result sign
  assign overflow = (opA[7] == opB[7]) && (full[7] != opA[7]);
  assign negative = full[7];
  assign zero = (full[7:0] == 8'h00);
endmodule // add8_flags

/* hw/add_exec.sv */
// module: decode and four-phase execution of the three add instructions
// What this block does
// - register-add sums accumulator and file register
// - dest bit picks accumulator or file
// - bank bit zero selects fixed access bank
// - bank bit one uses bank select register
// - extended mode, low address: indexed literal offset
// - add-with-carry sums accumulator, carry and memory
// - add-with-carry dest bit picks accumulator or memory
// - adds update five flags, keep other bits
`timescale 1ns/1ps
module add_exec (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [add_exec_pkg::REG_ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  input wire logic instrValid,
  input wire logic [15:0] instrWord,
  output logic instrReady,
  output logic instrDone,
  output logic [11:0] memAddr,
  output logic memRdEn,
  input wire logic [7:0] memRdData,
  output logic memWrEn,
  output logic [7:0] memWrData
);
  import add_exec_pkg::*;

  // ****************************************************************
  // state and registers
  // ****************************************************************
  state_t state_q, state_d;
  op_t op_q;
  logic [15:0] instr_q;
  logic [7:0] acc_q, bank_q, status_q, ctrl_q;
  logic [11:0] indexBase_q;
  logic [7:0] regRdData_q;
  logic instrDone_q, memRdEn_q, memWrEn_q, instrReady_q;
  logic [11:0] memAddr_q;
  logic [7:0] memWrData_q;

  // ****************************************************************
  // decode
  // ****************************************************************
  logic [7:0] fileAddr, operandB, sum;
  logic destFile, bankBit, indexed, extOn, carryIn, take;
  logic cOut, dcOut, ovOut, nOut, zOut;
  logic [11:0] effAddr, accessAddr;
  op_t opDec;
  logic [7:0] statusNext;

  // opcode classes; anything else is accepted and retires with no effect
  assign opDec = (instrWord[15:8] == OPC_LIT) ? OP_LIT :
                 (instrWord[15:10] == OPC_WF) ? OP_WF :
                 (instrWord[15:10] == OPC_WFC) ? OP_WFC : OP_NONE;
  assign take = instrValid && (state_q == ST_IDLE);
  assign fileAddr = instr_q[7:0];
  assign destFile = instr_q[INSTR_DEST_BIT];
  assign bankBit = instr_q[INSTR_BANK_BIT];
  assign extOn = ctrl_q[CTRL_EXT_BIT];

  // effective data address: indexed, access bank or banked
  assign indexed = !bankBit && extOn && (fileAddr <= INDEXED_MAX);
  assign accessAddr = {(fileAddr < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK,
                       fileAddr};
  assign effAddr = indexed ? 12'(indexBase_q + {4'h0, fileAddr}) :
                   !bankBit ? accessAddr :
                   {bank_q[3:0], fileAddr};

  // operand: the literal for the literal form, else the word read in the read phase
  assign operandB = (op_q == OP_LIT) ? instr_q[7:0] : memRdData;
  assign carryIn = (op_q == OP_WFC) && status_q[ST_C_BIT];

  add8_flags adder (
    .opA(acc_q),
    .opB(operandB),
    .carryIn(carryIn),
    .sum(sum),
    .carryOut(cOut),
    .digitCarry(dcOut),
    .overflow(ovOut),
    .negative(nOut),
    .zero(zOut)
  );

  // only the five arithmetic flags change, upper bits ride through
  assign statusNext = {status_q[7:5], nOut, ovOut, zOut, dcOut, cOut};

  // ****************************************************************
  // phase sequencer: decode, read, process, write
  // ****************************************************************
  // fixed four phases per instruction so timing never depends on the operand
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (take) state_d = ST_DECODE;
      ST_DECODE: state_d = ST_READ;
      ST_READ: state_d = ST_PROCESS;
      ST_PROCESS: state_d = ST_WRITE;
      ST_WRITE: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // ready is its own flop so the port never carries decode glitches
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      instr_q <= 16'h0000;
      op_q <= OP_NONE;
      instrReady_q <= 1'b1;
    end else begin
      state_q <= state_d;
      instrReady_q <= (state_d == ST_IDLE);
      if (take) begin
        instr_q <= instrWord;
        op_q <= opDec;
      end
    end
  end

  // ****************************************************************
  // data memory strobes
  // ****************************************************************
  // the literal form never touches data memory
  always_ff @(posedge clk) begin
    if (!resetn) begin
      memAddr_q <= 12'h000;
      memRdEn_q <= 1'b0;
      memWrEn_q <= 1'b0;
      memWrData_q <= 8'h00;
      instrDone_q <= 1'b0;
    end else begin
      memRdEn_q <= (state_q == ST_DECODE) && (op_q == OP_WF || op_q == OP_WFC);
      if (state_q == ST_DECODE) memAddr_q <= effAddr;
      memWrEn_q <= (state_q == ST_PROCESS) && destFile &&
                   (op_q == OP_WF || op_q == OP_WFC);
      if (state_q == ST_PROCESS) memWrData_q <= sum;
      instrDone_q <= (state_q == ST_WRITE);
    end
  end

  // ****************************************************************
  // software registers and architectural results
  // ****************************************************************
  logic execDone, accWrite;
  assign execDone = (state_q == ST_PROCESS) && (op_q != OP_NONE);
  assign accWrite = execDone && ((op_q == OP_LIT) || !destFile);

  // the executing instruction wins over a software write in the same cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      acc_q <= ACC_RST;
      status_q <= STATUS_RST;
    end else begin
      if (accWrite) acc_q <= sum;
      else if (regWrEn && regAddr == REG_ACC) acc_q <= regWrData;
      if (execDone) status_q <= statusNext;
      else if (regWrEn && regAddr == REG_STATUS) status_q <= regWrData;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      bank_q <= BANK_RST;
      ctrl_q <= CTRL_RST;
      indexBase_q <= INDEX_RST;
    end else if (regWrEn) begin
      if (regAddr == REG_BANK) bank_q <= regWrData;
      if (regAddr == REG_CTRL) ctrl_q <= regWrData;
      if (regAddr == REG_INDEX_LO) indexBase_q[7:0] <= regWrData;
      if (regAddr == REG_INDEX_HI) indexBase_q[11:8] <= regWrData[3:0];
    end
  end

  // read mux; unmapped offsets read zero
  logic [7:0] rdMux;
  assign rdMux = (regAddr == REG_ACC) ? acc_q :
                 (regAddr == REG_BANK) ? bank_q :
                 (regAddr == REG_STATUS) ? status_q :
                 (regAddr == REG_CTRL) ? ctrl_q :
                 (regAddr == REG_INDEX_LO) ? indexBase_q[7:0] :
                 (regAddr == REG_INDEX_HI) ? {4'h0, indexBase_q[11:8]} : 8'h00;

  always_ff @(posedge clk) begin
    if (!resetn) regRdData_q <= 8'h00;
    else regRdData_q <= regRdEn ? rdMux : 8'h00;
  end

  assign regRdData = regRdData_q;
  assign instrReady = instrReady_q;
  assign instrDone = instrDone_q;
  assign memAddr = memAddr_q;
  assign memRdEn = memRdEn_q;
  assign memWrEn = memWrEn_q;
  assign memWrData = memWrData_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_four_phases;
    @(posedge clk) disable iff (!resetn)
    take |=> (state_q == ST_DECODE) ##1 (state_q == ST_READ) ##1 (state_q == ST_PROCESS)
      ##1 (state_q == ST_WRITE && !instrReady) ##1 instrDone;
  endproperty
  a_four_phases: assert property (p_four_phases) else $error("add not four phases");

  property p_wf_file;
    @(posedge clk) disable iff (!resetn)
    (state_q == ST_PROCESS && op_q == OP_WF && destFile) |=>
      memWrEn && memWrData == $past(8'(acc_q + memRdData));
  endproperty
  a_wf_file: assert property (p_wf_file) else $error("register add file result wrong");

  property p_wf_acc;
    @(posedge clk) disable iff (!resetn)
    (state_q == ST_PROCESS && op_q == OP_WF && !destFile) |=>
      !memWrEn && acc_q == $past(8'(acc_q + memRdData));
  endproperty
  a_wf_acc: assert property (p_wf_acc) else $error("register add acc result wrong");

  property p_access_bank;
    @(posedge clk) disable iff (!resetn)
    (state_q == ST_DECODE && !bankBit && !indexed) |=> memAddr ==
      {($past(fileAddr) < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK, $past(fileAddr)};
  endproperty
  a_access_bank: assert property (p_access_bank) else $error("access bank address wrong");

  property p_banked;
    @(posedge clk) disable iff (!resetn)
    (state_q == ST_DECODE && bankBit) |=> memAddr == {$past(bank_q[3:0]), $past(fileAddr)};
  endproperty
  a_banked: assert property (p_banked) else $error("banked address wrong");

  property p_indexed;
    @(posedge clk) disable iff (!resetn)
    (state_q == ST_DECODE && !bankBit && extOn && fileAddr <= INDEXED_MAX) |=>
      memAddr == $past(12'(indexBase_q + {4'h0, fileAddr}));
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed address wrong");

  property p_wfc_sum;
    @(posedge clk) disable iff (!resetn)
    (state_q == ST_PROCESS && op_q == OP_WFC) |=> (destFile ? memWrData : acc_q) ==
      $past(8'(acc_q + memRdData + {7'h00, status_q[ST_C_BIT]}));
  endproperty
  a_wfc_sum: assert property (p_wfc_sum) else $error("carry add result wrong");

  property p_wfc_dest;
    @(posedge clk) disable iff (!resetn)
    (state_q == ST_PROCESS && op_q == OP_WFC) |=> memWrEn == $past(destFile);
  endproperty
  a_wfc_dest: assert property (p_wfc_dest) else $error("carry add destination wrong");

  property p_flags;
    @(posedge clk) disable iff (!resetn)
    execDone |=> status_q[7:5] == $past(status_q[7:5]) &&
      status_q[ST_Z_BIT] == ($past(sum) == 8'h00) && status_q[ST_N_BIT] == $past(sum[7]);
  endproperty
  a_flags: assert property (p_flags) else $error("status flags wrong");

  property p_literal;
    @(posedge clk) disable iff (!resetn)
    (state_q == ST_PROCESS && op_q == OP_LIT) |=>
      acc_q == $past(8'(acc_q + instr_q[7:0])) && !memWrEn;
  endproperty
  a_literal: assert property (p_literal) else $error("literal add wrong");

  c_lit: cover property (@(posedge clk) disable iff (!resetn) execDone && op_q == OP_LIT);
  c_wf_file: cover property (@(posedge clk) disable iff (!resetn) memWrEn);
  c_indexed: cover property (@(posedge clk) disable iff (!resetn)
    state_q == ST_DECODE && indexed);
  c_carry: cover property (@(posedge clk) disable iff (!resetn)
    execDone && op_q == OP_WFC && carryIn);
endmodule // add_exec

/* tb/tb_top.sv */
// testbench: drives the add datapath through its register and instruction ports
`timescale 1ns/1ps
module tb_top;
  import add_exec_pkg::*;
  logic clk;
  logic resetn;
  logic [REG_ADDR_W-1:0] regAddr;
  logic [7:0] regWrData;
  logic regWrEn;
  logic regRdEn;
  logic [7:0] regRdData;
  logic instrValid;
  logic [15:0] instrWord;
  logic instrReady;
  logic instrDone;
  logic [11:0] memAddr;
  logic memRdEn;
  logic [7:0] memRdData = 8'h00;
  logic memWrEn;
  logic [7:0] memWrData;
  logic [7:0] memVal;
  int miscompares = 0;
  int numChecks = 0;

  add_exec DUT (.clk(clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .instrValid(instrValid),
    .instrWord(instrWord), .instrReady(instrReady), .instrDone(instrDone),
    .memAddr(memAddr), .memRdEn(memRdEn), .memRdData(memRdData), .memWrEn(memWrEn),
    .memWrData(memWrData));

  // ****************************************************************
  // clock, data memory stand-in, watchdog
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // read data only valid the cycle after a read; otherwise it toggles so stale data shows
  always @(posedge clk) begin
    memRdData <= memRdEn ? memVal : ~memRdData;
  end

  // about 150 cycles of work; a hang is cut off well past that
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    complete_run();
  end

  // ****************************************************************
  // compare, bus and instruction tasks
  // ****************************************************************
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    numChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk12(input logic [11:0] got, input logic [11:0] exp);
    numChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic regWrite(input logic [2:0] addr, input logic [7:0] data);
    @(posedge clk);
    regWrEn <= 1'b1;
    regAddr <= addr;
    regWrData <= data;
    @(posedge clk);
    regWrEn <= 1'b0;
  endtask

  task automatic regCheck(input logic [2:0] addr, input logic [7:0] exp);
    @(posedge clk);
    regRdEn <= 1'b1;
    regAddr <= addr;
    @(posedge clk);
    regRdEn <= 1'b0;
    #1;
    chk8(regRdData, exp);
  endtask

  // offers one word, follows its five cycles and judges the memory traffic
  task automatic execInstr(input logic [15:0] word, input logic [7:0] rdVal,
    input logic [11:0] expAddr, input logic expRd, input logic expWr,
    input logic [7:0] expWrData);
    int rdCnt;
    int wrCnt;
    logic [11:0] addrSeen;
    logic [7:0] wrSeen;
    rdCnt = 0;
    wrCnt = 0;
    addrSeen = 12'h000;
    wrSeen = 8'h00;
    memVal = rdVal;
    @(posedge clk);
    instrValid <= 1'b1;
    instrWord <= word;
    for (int i = 1; i <= 5; i++) begin
      @(posedge clk);
      if (i == 1) begin
        instrValid <= 1'b0;
      end
      #1;
      if (memRdEn === 1'b1) begin
        rdCnt++;
        addrSeen = memAddr;
      end
      if (memWrEn === 1'b1) begin
        wrCnt++;
        addrSeen = memAddr;
        wrSeen = memWrData;
      end
      chk8({7'h00, instrDone}, {7'h00, i == 5});
      chk8({7'h00, instrReady}, {7'h00, i == 5});
    end
    chk8(8'(rdCnt), {7'h00, expRd});
    chk8(8'(wrCnt), {7'h00, expWr});
    if (expRd || expWr) begin
      chk12(addrSeen, expAddr);
    end
    if (expWr) begin
      chk8(wrSeen, expWrData);
    end
  endtask

  task automatic accStatus(input logic [7:0] expAcc, input logic [7:0] expSt);
    regCheck(REG_ACC, expAcc);
    regCheck(REG_STATUS, expSt);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic resetAndRegs();
    regCheck(REG_ACC, ACC_RST);
    regCheck(REG_STATUS, STATUS_RST);
    regCheck(REG_CTRL, CTRL_RST);
    regWrite(REG_BANK, 8'h05);
    regWrite(3'h7, 8'hAA);
    regCheck(REG_BANK, 8'h05);
    regCheck(3'h6, 8'h00);
    regCheck(3'h7, 8'h00);
  endtask

  // literal add: plain, half-carry with signed overflow, wrap to zero with carry
  task automatic literalAdds();
    logic [7:0] accIn [3] = '{8'h10, 8'h7F, 8'h80};
    logic [7:0] lit [3] = '{8'h15, 8'h01, 8'h80};
    logic [7:0] sumExp [3] = '{8'h25, 8'h80, 8'h00};
    logic [7:0] stExp [3] = '{8'hE0, 8'hFA, 8'hED};
    regWrite(REG_STATUS, 8'hE0);
    for (int i = 0; i < 3; i++) begin
      regWrite(REG_ACC, accIn[i]);
      execInstr({8'h0F, lit[i]}, 8'h00, 12'h000, 1'b0, 1'b0, 8'h00);
      accStatus(sumExp[i], stExp[i]);
    end
    // an opcode outside the add family retires with no effect
    execInstr(16'h0B05, 8'h00, 12'h000, 1'b0, 1'b0, 8'h00);
    accStatus(8'h00, 8'hED);
  endtask

  task automatic fileAdds();
    regWrite(REG_ACC, 8'h17);
    execInstr(16'h2533, 8'hC2, 12'h533, 1'b1, 1'b0, 8'h00);
    accStatus(8'hD9, 8'hF0);
    regWrite(REG_ACC, 8'hFF);
    execInstr(16'h26A0, 8'h01, 12'hFA0, 1'b1, 1'b1, 8'h00);
    accStatus(8'hFF, 8'hE7);
    execInstr(16'h2620, 8'h00, 12'h020, 1'b1, 1'b1, 8'hFF);
  endtask

  task automatic carryAdds();
    regWrite(REG_STATUS, 8'hE1);
    regWrite(REG_CTRL, 8'h01);
    regWrite(REG_INDEX_LO, 8'hF0);
    regWrite(REG_INDEX_HI, 8'h03);
    regWrite(REG_ACC, 8'h4D);
    execInstr(16'h225F, 8'h02, 12'h44F, 1'b1, 1'b1, 8'h50);
    accStatus(8'h4D, 8'hE2);
    execInstr(16'h2260, 8'h10, 12'hF60, 1'b1, 1'b1, 8'h5D);
    execInstr(16'h205F, 8'h02, 12'h44F, 1'b1, 1'b0, 8'h00);
    accStatus(8'h4F, 8'hE0);
  endtask

  task automatic complete_run();
    if (miscompares == 0 && numChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    resetn = 1'b0;
    regAddr = 3'h0;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    instrValid = 1'b0;
    instrWord = 16'h0000;
    memVal = 8'h00;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    resetAndRegs();
    literalAdds();
    fileAdds();
    carryAdds();
    complete_run();
  end
endmodule // tb_top
